// ### rtl/spi_chunk_pkg.sv
`default_nettype none
package spi_chunk_pkg;
	localparam int MSB = 31;
	localparam int PHASE_BIT = 4;
	localparam logic [4:0] BIT_LAST = 5'h1F;
	localparam logic [2:0] SYNC_IDLE = 3'h1;
	localparam logic [1:0] CHUNK_SEL_8 = 2'h0;
	localparam logic [1:0] CHUNK_SEL_16 = 2'h1;
	localparam logic [1:0] CHUNK_SEL_32 = 2'h2;
	localparam logic [1:0] CHUNK_SEL_64 = 2'h3;
	localparam logic [1:0] CHUNK_SEL_DEFAULT = CHUNK_SEL_64;
	localparam logic [4:0] WORDS_AT_SEL0 = 5'h2;
	localparam logic [1:0] STAMP_NONE = 2'h0;
	localparam logic [1:0] STAMP_A = 2'h1;
	localparam logic [1:0] STAMP_B = 2'h2;
	localparam logic [1:0] STAMP_C = 2'h3;
	localparam int STAT_TX_PROTOCOL_ERROR = 0;
	localparam int STAT_CAP_BASE = 8;

	typedef struct packed {
		logic hi;
		logic lo;
	} vs_type;

	typedef struct packed {
		logic [3:0] word;
		logic [1:0] lane;
	} off_type;

	typedef struct packed {
		logic [13:0] words;
		logic [1:0] lane;
	} size_type;

	typedef struct packed {
		logic lead_one;
		logic chunk_sequence_bit;
		logic no_receive_flag;
		logic [4:0] rsvd_hi;
		vs_type vendor_bits;
		logic data_valid_bit;
		logic start_valid_bit;
		logic [3:0] start_word_offset;
		logic rsvd_mid;
		logic end_valid_bit;
		off_type end_byte_offset;
		logic [1:0] tx_stamp_request;
		logic [4:0] rsvd_lo;
		logic parity;
	} header_type;

	typedef struct packed {
		logic extended_status_bit;
		logic header_bad_bit;
		logic cfg_synced;
		logic [4:0] rx_chunks_available;
		vs_type vendor_bits;
		logic data_valid_bit;
		logic start_valid_bit;
		logic [3:0] start_word_offset;
		logic frame_drop_bit;
		logic end_valid_bit;
		off_type end_byte_offset;
		logic rx_stamp_added;
		logic stamp_parity;
		logic [4:0] tx_credits;
		logic parity;
	} footer_type;

	typedef struct packed {
		logic [31:0] word;
		logic sof;
		logic eof;
		logic [1:0] last_lane;
		logic drop;
		logic stamp;
		logic port;
		logic prio;
	} rx_item_type;

	typedef struct packed {
		logic [31:0] word;
		logic sof;
		logic eof;
		logic [1:0] last_lane;
		logic port;
		logic [1:0] stamp;
	} tx_item_type;

	function automatic logic [4:0] payload_words(input logic [1:0] sel);
		payload_words = WORDS_AT_SEL0 << sel;
	endfunction

	function automatic logic odd_par(input logic [31:0] w);
		odd_par = ~^w[MSB:1];
	endfunction
endpackage
`default_nettype wire

// ### rtl/spi_chunk_frame_port.sv
`default_nettype none
// Overview of operation
// - A generic-mode size write failing its CRC leaves the size register unchanged.
// - Size write while words of the previous frame are outstanding raises protocol error.
// - Transmit chunks start with a 4-byte header; receive chunks end with a footer.
// - Payload size defaults to 64 bytes, selectable as 8, 16, 32 or 64.
// - Transactions carry 1..N chunks, equal count both ways, validity independent.
// - Frames start only on 32-bit word boundaries inside a payload.
// - Header vendor bit 0 routes the frame to port 1 or port 2.
// - Payload of a chunk whose header data-valid bit is clear is ignored.
// - Start-valid with 4-bit start offset marks the word where a frame begins.
// - End-valid with 6-bit end offset marks the last frame byte in payload.
// - Stamp request selects none or slot A, B, C; capture sets matching flag.
// - Header and footer bit 0 carry odd parity over their word.
// - Footer extended status is set when any unmasked status bit is set.
// - Footer reports the minimum number of further receive chunks pending.
// - Footer vendor bits show priority queue and source port of the frame.
// - Footer frame-drop bit is set only together with end-valid.
// - Prepended receive stamp sets stamp-added and start offset points at it.
// - Footer transmit credits give chunks the host may send without overflow.
module spi_chunk_frame_port (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Serial link
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	// Configuration
	input wire logic [1:0] chunk_sel_i,
	input wire logic xfer_enable_i,
	input wire logic cfg_sync_i,
	output logic [1:0] chunk_sel_o,
	// Receive frame source
	input wire spi_chunk_pkg::rx_item_type rx_item_i,
	input wire logic rx_valid_i,
	output logic rx_ready_o,
	input wire logic [4:0] rx_chunks_i,
	input wire logic [4:0] tx_credits_i,
	// Transmit frame sink
	output spi_chunk_pkg::tx_item_type tx_item_o,
	output logic tx_valid_o,
	// Stamp capture and status
	input wire logic capture_event_i,
	input wire logic [1:0] capture_slot_i,
	input wire logic [31:0] status_reg_zero_ext_i,
	input wire logic [31:0] status_one_i,
	input wire logic [31:0] mask0_i,
	input wire logic [31:0] mask1_i,
	input wire logic [31:0] status_clear_i,
	output logic [31:0] status_reg_zero_o,
	output logic header_bad_o,
	// Generic mode
	input wire logic gen_fsize_wr_i,
	input wire logic gen_data_wr_i,
	input wire logic gen_crc_ok_i,
	input wire logic [15:0] gen_wdata_i,
	output logic [15:0] tx_frame_size_reg_o,
	output logic tx_protocol_error_o
);
	logic [4:0] ocnt_r, icnt_r;
	logic [31:0] out_shift_r, in_shift_r, in_hold_r, next_word_r;
	logic miso_r;
	logic [2:0] s1_r, s2_r, s3_r, f_r, fp_r;
	logic in_evt, ld_evt, cs_end;
	logic [1:0] sel_r;
	logic [4:0] words;
	logic [4:0] prep_idx_r, nidx, in_idx_r;
	logic [31:0] word_nxt;
	spi_chunk_pkg::footer_type acc_r, acc_nxt, foot;
	logic take, foot_load, extended_status_bit_c;
	logic rx_ready_r;
	spi_chunk_pkg::header_type hdr_r, hdr_in;
	logic hdr_ok_r, in_frame_r, header_bad_bit_r;
	logic chunk_valid, st_c, cur_c, end_c;
	logic [3:0] pj;
	logic tx_valid_r;
	spi_chunk_pkg::tx_item_type tx_item_r;
	logic [spi_chunk_pkg::STAMP_C:spi_chunk_pkg::STAMP_A] cap_r;
	logic tx_protocol_error_r;
	logic [15:0] fsize_r;
	logic [13:0] remain_r;
	spi_chunk_pkg::size_type wsize;
	logic [31:0] own_c, status_reg_zero_r;

	// Link side: shift out on rising edge, sample on falling edge
	always_ff @(posedge spi_sclk_i or posedge spi_cs_n_i) begin
		if (spi_cs_n_i) begin
			ocnt_r <= '0;
			miso_r <= 1'b0;
		end else begin
			ocnt_r <= ocnt_r + 5'h1;
			if (ocnt_r == '0)
				miso_r <= next_word_r[spi_chunk_pkg::MSB];
			else
				miso_r <= out_shift_r[spi_chunk_pkg::MSB-1];
		end
	end

	// Next word is stable here: it was prepared half a word earlier
	always_ff @(posedge spi_sclk_i) begin
		if (ocnt_r == '0)
			out_shift_r <= next_word_r;
		else
			out_shift_r <= out_shift_r << 1;
	end

	always_ff @(negedge spi_sclk_i or posedge spi_cs_n_i) begin
		if (spi_cs_n_i)
			icnt_r <= '0;
		else
			icnt_r <= icnt_r + 5'h1;
	end

	always_ff @(negedge spi_sclk_i) begin
		in_shift_r <= {in_shift_r[spi_chunk_pkg::MSB-1:0], spi_mosi_i};
		if (icnt_r == spi_chunk_pkg::BIT_LAST)
			in_hold_r <= {in_shift_r[spi_chunk_pkg::MSB-1:0], spi_mosi_i};
	end

	assign spi_miso_o = miso_r;

	// Counter phase bits cross as levels; held words are read only after them
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			s1_r <= spi_chunk_pkg::SYNC_IDLE;
			s2_r <= spi_chunk_pkg::SYNC_IDLE;
			s3_r <= spi_chunk_pkg::SYNC_IDLE;
			f_r <= spi_chunk_pkg::SYNC_IDLE;
			fp_r <= spi_chunk_pkg::SYNC_IDLE;
		end else begin
			s1_r <= {ocnt_r[spi_chunk_pkg::PHASE_BIT], icnt_r[spi_chunk_pkg::PHASE_BIT],
				spi_cs_n_i};
			s2_r <= s1_r;
			s3_r <= s2_r;
			f_r <= (s2_r & s3_r) | (f_r & (s2_r | s3_r));
			fp_r <= f_r;
		end
	end

	assign ld_evt = f_r[2] & ~fp_r[2];
	assign in_evt = fp_r[1] & ~f_r[1];
	assign cs_end = f_r[0] & ~fp_r[0];

	// Size only follows the selector while transfer is off
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i)
			sel_r <= spi_chunk_pkg::CHUNK_SEL_DEFAULT;
		else if (!xfer_enable_i)
			sel_r <= chunk_sel_i;
	end

	assign chunk_sel_o = sel_r;
	assign words = spi_chunk_pkg::payload_words(sel_r);

	// Receive direction: payload words then footer, one word ahead
	always_comb begin
		nidx = (prep_idx_r == words) ? '0 : prep_idx_r + 5'h1;
		take = 1'b0;
		word_nxt = '0;
		acc_nxt = acc_r;
		extended_status_bit_c = (|(status_reg_zero_r & ~mask0_i)) | (|(status_one_i & ~mask1_i));
		foot = acc_r;
		foot.extended_status_bit = extended_status_bit_c;
		foot.header_bad_bit = header_bad_bit_r;
		foot.cfg_synced = cfg_sync_i;
		foot.rx_chunks_available = rx_chunks_i;
		foot.tx_credits = tx_credits_i;
		foot.stamp_parity = 1'b0;
		foot.parity = spi_chunk_pkg::odd_par(foot);
		if (nidx == words) begin
			word_nxt = foot;
			acc_nxt = '0;
			acc_nxt.vendor_bits = acc_r.vendor_bits;
		end else if (rx_valid_i && xfer_enable_i && !(hdr_ok_r && hdr_r.no_receive_flag)) begin
			take = 1'b1;
			word_nxt = rx_item_i.word;
			acc_nxt.data_valid_bit = 1'b1;
			if (rx_item_i.sof) begin
				acc_nxt.start_valid_bit = 1'b1;
				acc_nxt.start_word_offset = nidx[3:0];
				acc_nxt.rx_stamp_added = rx_item_i.stamp;
				acc_nxt.vendor_bits.hi = rx_item_i.prio;
				acc_nxt.vendor_bits.lo = rx_item_i.port;
			end
			if (rx_item_i.eof) begin
				acc_nxt.end_valid_bit = 1'b1;
				acc_nxt.end_byte_offset.word = nidx[3:0];
				acc_nxt.end_byte_offset.lane = rx_item_i.last_lane;
				acc_nxt.frame_drop_bit = rx_item_i.drop;
			end
		end
	end

	assign foot_load = ld_evt && (nidx == words);

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			prep_idx_r <= '0;
			next_word_r <= '0;
			acc_r <= '0;
			rx_ready_r <= 1'b0;
		end else begin
			rx_ready_r <= ld_evt && take;
			if (ld_evt) begin
				prep_idx_r <= nidx;
				next_word_r <= word_nxt;
				acc_r <= acc_nxt;
			end
		end
	end

	assign rx_ready_o = rx_ready_r;

	// Transmit direction: header then payload words
	assign hdr_in = in_hold_r;
	assign chunk_valid = hdr_ok_r && hdr_r.data_valid_bit && xfer_enable_i;
	assign pj = 4'(in_idx_r - 5'h1);
	assign st_c = chunk_valid && hdr_r.start_valid_bit && (pj == hdr_r.start_word_offset);
	assign cur_c = in_frame_r || st_c;
	assign end_c = cur_c && chunk_valid && hdr_r.end_valid_bit
		&& (pj == hdr_r.end_byte_offset.word);

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			in_idx_r <= '0;
			hdr_r <= '0;
			hdr_ok_r <= 1'b0;
			in_frame_r <= 1'b0;
			tx_valid_r <= 1'b0;
			tx_item_r <= '0;
		end else begin
			tx_valid_r <= 1'b0;
			if (cs_end) begin
				in_idx_r <= '0;
			end else if (in_evt) begin
				in_idx_r <= (in_idx_r == words) ? '0 : in_idx_r + 5'h1;
				if (in_idx_r == '0) begin
					hdr_r <= hdr_in;
					hdr_ok_r <= (spi_chunk_pkg::odd_par(in_hold_r) == hdr_in.parity);
				end else if (chunk_valid) begin
					in_frame_r <= cur_c && !end_c;
					if (cur_c) begin
						tx_valid_r <= 1'b1;
						tx_item_r.word <= in_hold_r;
						tx_item_r.sof <= st_c;
						tx_item_r.eof <= end_c;
						tx_item_r.last_lane <= hdr_r.end_byte_offset.lane;
						tx_item_r.port <= hdr_r.vendor_bits.lo;
						tx_item_r.stamp <= hdr_r.tx_stamp_request;
					end
				end
			end
		end
	end

	assign tx_valid_o = tx_valid_r;
	assign tx_item_o = tx_item_r;

	// Bad header parity is reported in the next footer
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i)
			header_bad_bit_r <= 1'b0;
		else if (in_evt && in_idx_r == '0 && spi_chunk_pkg::odd_par(in_hold_r) != hdr_in.parity)
			header_bad_bit_r <= 1'b1;
		else if (foot_load)
			header_bad_bit_r <= 1'b0;
	end

	assign header_bad_o = header_bad_bit_r;

	// Capture flags: a new capture beats a clear in the same cycle
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			cap_r <= '0;
		end else begin
			for (int k = spi_chunk_pkg::STAMP_A; k <= spi_chunk_pkg::STAMP_C; k++) begin
				if (capture_event_i && capture_slot_i == 2'(k))
					cap_r[k] <= 1'b1;
				else if (status_clear_i[spi_chunk_pkg::STAT_CAP_BASE + k])
					cap_r[k] <= 1'b0;
			end
		end
	end

	// Generic mode size register and outstanding word count
	assign wsize = gen_wdata_i;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			fsize_r <= '0;
			remain_r <= '0;
		end else if (gen_fsize_wr_i && gen_crc_ok_i) begin
			fsize_r <= gen_wdata_i;
			remain_r <= wsize.words + 14'(|wsize.lane);
		end else if (gen_data_wr_i && gen_crc_ok_i && remain_r != '0) begin
			remain_r <= remain_r - 14'h1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i)
			tx_protocol_error_r <= 1'b0;
		else if (gen_fsize_wr_i && gen_crc_ok_i && remain_r != '0)
			tx_protocol_error_r <= 1'b1;
		else if (status_clear_i[spi_chunk_pkg::STAT_TX_PROTOCOL_ERROR])
			tx_protocol_error_r <= 1'b0;
	end

	assign tx_frame_size_reg_o = fsize_r;
	assign tx_protocol_error_o = tx_protocol_error_r;

	always_comb begin
		own_c = '0;
		own_c[spi_chunk_pkg::STAT_TX_PROTOCOL_ERROR] = tx_protocol_error_r;
		for (int k = spi_chunk_pkg::STAMP_A; k <= spi_chunk_pkg::STAMP_C; k++)
			own_c[spi_chunk_pkg::STAT_CAP_BASE + k] = cap_r[k];
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i)
			status_reg_zero_r <= '0;
		else
			status_reg_zero_r <= status_reg_zero_ext_i | own_c;
	end

	assign status_reg_zero_o = status_reg_zero_r;

	// Checks on the reference clock side
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	spi_chunk_pkg::footer_type nw;
	assign nw = next_word_r;

	sequence fsize_early;
		gen_fsize_wr_i && gen_crc_ok_i && remain_r != '0;
	endsequence

	sequence foot_built;
		ld_evt && nidx == words;
	endsequence

	crc_hold_a: assert property (gen_fsize_wr_i && !gen_crc_ok_i |=> $stable(fsize_r))
		else $error("size register changed on failed CRC");
	tx_protocol_error_raise_a: assert property (fsize_early |=> tx_protocol_error_r)
		else $error("protocol error not raised");
	sel_freeze_a: assert property (xfer_enable_i |=> $stable(sel_r))
		else $error("payload size changed while enabled");
	sel_default_a: assert property ($rose(rst_n_i) |-> sel_r == spi_chunk_pkg::CHUNK_SEL_DEFAULT)
		else $error("payload size not default after reset");
	foot_par_a: assert property (foot_built |=> ^next_word_r)
		else $error("footer parity not odd");
	foot_drop_a: assert property (foot_built |=> !nw.frame_drop_bit || nw.end_valid_bit)
		else $error("frame drop without end valid");
	foot_stamp_a: assert property (foot_built |=> !nw.rx_stamp_added || nw.start_valid_bit)
		else $error("stamp added without start valid");
	foot_extended_status_bit_a: assert property (foot_built |=> nw.extended_status_bit == $past(extended_status_bit_c))
		else $error("extended status mismatch");
	foot_credit_a: assert property (foot_built |=> nw.tx_credits == $past(tx_credits_i))
		else $error("transmit credits mismatch");
	hdr_ignore_a: assert property (tx_valid_o |-> $past(chunk_valid))
		else $error("payload taken from invalid chunk");
	route_a: assert property (tx_valid_o |-> tx_item_o.port == $past(hdr_r.vendor_bits.lo))
		else $error("frame routed to wrong port");
	cap_a_a: assert property (capture_event_i && capture_slot_i == spi_chunk_pkg::STAMP_A
		|=> cap_r[spi_chunk_pkg::STAMP_A] ##1 status_reg_zero_o[spi_chunk_pkg::STAT_CAP_BASE
		+ spi_chunk_pkg::STAMP_A])
		else $error("capture A flag not set");
endmodule
`default_nettype wire

// ### dv/spi_host_model.sv
`default_nettype none
module spi_host_model (
	// Serial link
	output logic spi_sclk_o,
	output logic spi_cs_n_o,
	output logic spi_mosi_o,
	input wire logic spi_miso_i
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF = 80;
	logic [31:0] tx_w [0:16];
	logic [31:0] rx_w [0:16];
	initial begin
		spi_sclk_o = 1'b0;
		spi_cs_n_o = 1'b1;
		spi_mosi_o = 1'b0;
	end
	// Mode 1: drive on rising, sample on falling; header leaves first
	task automatic run(input int n);
		spi_cs_n_o = 1'b0;
		#(HALF);
		for (int w = 0; w < n; w++) begin
			for (int b = 31; b >= 0; b--) begin
				spi_sclk_o = 1'b1;
				spi_mosi_o = tx_w[w][b];
				#(HALF);
				rx_w[w][b] = spi_miso_i;
				spi_sclk_o = 1'b0;
				#(HALF);
			end
		end
		spi_cs_n_o = 1'b1;
		// Released line must not look held
		spi_mosi_o = ~spi_mosi_o;
		// Deselect gap before any further transaction
		#(8 * HALF);
	endtask
endmodule
`default_nettype wire

// ### dv/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] PAY0 = 32'h1234ABCD;
	localparam logic [31:0] PAY1 = 32'h00FF5A3C;
	localparam logic [31:0] RXW = 32'hA5C30F96;
	logic ref_clk_i;
	logic rst_n_i = 1'b0;
	wire logic spi_sclk_i;
	wire logic spi_cs_n_i;
	wire logic spi_mosi_i;
	logic spi_miso_o;
	logic [1:0] chunk_sel_i = 2'h3;
	logic xfer_enable_i = 1'b0;
	logic cfg_sync_i = 1'b1;
	logic [1:0] chunk_sel_o;
	spi_chunk_pkg::rx_item_type rx_item_i = '{RXW, 1'b1, 1'b1, 2'h2, 1'b1, 1'b0, 1'b1, 1'b1};
	logic rx_valid_i = 1'b0;
	logic rx_ready_o;
	logic [4:0] rx_chunks_i = 5'h13;
	logic [4:0] tx_credits_i = 5'h0A;
	spi_chunk_pkg::tx_item_type tx_item_o;
	logic tx_valid_o;
	logic capture_event_i = 1'b0;
	logic [1:0] capture_slot_i = 2'h0;
	logic [31:0] status_reg_zero_ext_i = 32'h00000000;
	logic [31:0] status_one_i = 32'h00000008;
	logic [31:0] mask0_i = 32'hFFFFFFFF;
	logic [31:0] mask1_i = 32'h00000000;
	logic [31:0] status_clear_i = 32'h00000000;
	logic [31:0] status_reg_zero_o;
	logic header_bad_o;
	logic gen_fsize_wr_i = 1'b0;
	logic gen_data_wr_i = 1'b0;
	logic gen_crc_ok_i = 1'b0;
	logic [15:0] gen_wdata_i = 16'h0000;
	logic [15:0] tx_frame_size_reg_o;
	logic tx_protocol_error_o;
	int mismatches = 0;
	int comparisons = 0;
	int takes = 0;
	spi_chunk_pkg::tx_item_type tx_seen[$];
	spi_chunk_pkg::footer_type ftr;

	spi_chunk_frame_port uut (
		.ref_clk_i, .rst_n_i, .spi_sclk_i, .spi_cs_n_i, .spi_mosi_i, .spi_miso_o,
		.chunk_sel_i, .xfer_enable_i, .cfg_sync_i, .chunk_sel_o, .rx_item_i, .rx_valid_i,
		.rx_ready_o, .rx_chunks_i, .tx_credits_i, .tx_item_o, .tx_valid_o, .capture_event_i,
		.capture_slot_i, .status_reg_zero_ext_i, .status_one_i, .mask0_i, .mask1_i, .status_clear_i,
		.status_reg_zero_o, .header_bad_o, .gen_fsize_wr_i, .gen_data_wr_i, .gen_crc_ok_i,
		.gen_wdata_i, .tx_frame_size_reg_o, .tx_protocol_error_o
	);
	spi_host_model host (
		.spi_sclk_o(spi_sclk_i), .spi_cs_n_o(spi_cs_n_i), .spi_mosi_o(spi_mosi_i),
		.spi_miso_i(spi_miso_o)
	);

	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		if (tx_valid_o === 1'b1) begin
			tx_seen.push_back(tx_item_o);
		end
		if (rx_ready_o === 1'b1) begin
			takes++;
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Ends off the edge so design updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
	endtask
	task automatic gen_wr(input logic size, input logic ok, input logic [15:0] v);
		@(posedge ref_clk_i);
		gen_fsize_wr_i <= size;
		gen_data_wr_i <= ~size;
		gen_crc_ok_i <= ok;
		gen_wdata_i <= v;
		@(posedge ref_clk_i);
		gen_fsize_wr_i <= 1'b0;
		gen_data_wr_i <= 1'b0;
		cyc(2);
	endtask
	task automatic gen_chk(input logic [15:0] sz, input logic err);
		check("tx_frame_size_reg_o", tx_frame_size_reg_o, sz);
		check("tx_protocol_error_o", tx_protocol_error_o, err);
		check("status bit0", status_reg_zero_o[0], err);
	endtask
	task automatic clear(input logic [31:0] bits);
		@(posedge ref_clk_i);
		status_clear_i <= bits;
		@(posedge ref_clk_i);
		status_clear_i <= 32'h00000000;
		cyc(2);
	endtask
	task automatic send(input logic [1:0] st, input logic dv, input logic flip);
		spi_chunk_pkg::header_type h;
		h = '0;
		h.lead_one = 1'b1;
		h.data_valid_bit = dv;
		h.start_valid_bit = 1'b1;
		h.end_valid_bit = 1'b1;
		h.end_byte_offset.word = 4'h1;
		h.end_byte_offset.lane = 2'h3;
		h.vendor_bits.lo = st[0];
		h.tx_stamp_request = st;
		h.parity = ~(^h[31:1]) ^ flip;
		host.tx_w[0] = h;
		host.tx_w[1] = PAY0;
		host.tx_w[2] = PAY1;
		tx_seen.delete();
		takes = 0;
		host.run(3);
		cyc(4);
		ftr = host.rx_w[2];
	endtask

	initial begin
		repeat (30000) @(posedge ref_clk_i);
		mismatches++;
		final_report();
	end

	initial begin
		repeat (16) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		cyc(1);
		check("chunk_sel_o", chunk_sel_o, spi_chunk_pkg::CHUNK_SEL_DEFAULT);
		gen_chk(16'h0000, 1'b0);
		for (int i = 3; i >= 0; i--) begin
			@(posedge ref_clk_i);
			chunk_sel_i <= 2'(i);
			cyc(2);
			check("chunk_sel_o", chunk_sel_o, 32'(i));
		end
		@(posedge ref_clk_i);
		xfer_enable_i <= 1'b1;
		rx_valid_i <= 1'b1;
		chunk_sel_i <= 2'h3;
		cyc(3);
		check("chunk_sel_o locked", chunk_sel_o, 32'h0);
		$display("test size select done");

		gen_wr(1'b1, 1'b0, 16'h0040);
		gen_chk(16'h0000, 1'b0);
		gen_wr(1'b1, 1'b1, 16'h0008);
		gen_chk(16'h0008, 1'b0);
		gen_wr(1'b1, 1'b1, 16'h0006);
		gen_chk(16'h0006, 1'b1);
		clear(32'h00000001);
		gen_chk(16'h0006, 1'b0);
		// A data word with failed CRC must not count
		gen_wr(1'b0, 1'b1, 16'h1111);
		gen_wr(1'b0, 1'b0, 16'h2222);
		gen_wr(1'b1, 1'b1, 16'h0006);
		gen_chk(16'h0006, 1'b1);
		clear(32'h00000001);
		gen_wr(1'b0, 1'b1, 16'h3333);
		gen_wr(1'b0, 1'b1, 16'h4444);
		gen_wr(1'b1, 1'b1, 16'h000C);
		gen_chk(16'h000C, 1'b0);
		$display("test generic mode done");

		for (int k = 1; k < 4; k++) begin
			@(posedge ref_clk_i);
			capture_event_i <= 1'b1;
			capture_slot_i <= 2'(k);
			@(posedge ref_clk_i);
			capture_event_i <= 1'b0;
			cyc(2);
			check("capture flags", status_reg_zero_o[11:9], 32'((1 << k) - 1));
		end
		clear(32'h00000E01);
		check("capture flags", status_reg_zero_o[11:9], 32'h0);
		$display("test capture flags done");

		for (int s = 0; s < 4; s++) begin
			@(posedge ref_clk_i);
			mask1_i <= s[1] ? 32'hFFFFFFFF : 32'h00000000;
			send(2'(s), 1'b1, 1'b0);
			check("tx words", tx_seen.size(), 32'h2);
			check("tx first", tx_seen[0].word, PAY0);
			check("tx sof", tx_seen[0].sof, 1'b1);
			check("tx port", tx_seen[0].port, 32'(s % 2));
			check("tx stamp", tx_seen[0].stamp, 32'(s));
			check("tx last", tx_seen[1].word, PAY1);
			check("tx eof", tx_seen[1].eof, 1'b1);
			check("tx lane", tx_seen[1].last_lane, 32'h3);
			check("rx word", host.rx_w[1], RXW);
			check("footer parity", ^ftr, 1'b1);
			check("extended status", ftr.extended_status_bit, 32'(1 - s / 2));
			check("rx chunks", ftr.rx_chunks_available, 32'h13);
			check("footer vendor", ftr.vendor_bits, 32'h3);
			check("drop alone", ftr.frame_drop_bit & ~ftr.end_valid_bit, 1'b0);
			check("frame drop", ftr.frame_drop_bit, 1'b1);
			check("stamp added", ftr.rx_stamp_added, 1'b0);
			check("header good", ftr.header_bad_bit, 1'b0);
			check("rx takes", takes, 32'h2);
			check("tx credits", ftr.tx_credits, 32'h0A);
		end
		send(2'h1, 1'b0, 1'b0);
		check("tx ignored", tx_seen.size(), 32'h0);
		send(2'h1, 1'b1, 1'b1);
		check("bad parity ignored", tx_seen.size(), 32'h0);
		check("header bad", ftr.header_bad_bit, 1'b1);
		check("header bad cleared", header_bad_o, 1'b0);
		$display("test frame chunks done");
		final_report();
	end
endmodule
`default_nettype wire
